// >>> ext_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// far side: pin clock bursts or gate levels, pins rest low between uses
module ext_pin_model #(
  parameter int W = 9
) (
  input wire logic clk,
  output logic [W-1:0] pin
);
  initial pin = '0;

  // four cycles per level so both sync stages see every edge
  task automatic pulses(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      pin[i] <= 1'b1;
      repeat (4) @(posedge clk);
      pin[i] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic gate(input int i, input int hi);
    @(posedge clk);
    pin[i] <= 1'b1;
    repeat (hi) @(posedge clk);
    pin[i] <= 1'b0;
  endtask
endmodule

// >>> timer_set.sv
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - standalone 16-bit counter: timer, synchronous counter, or pin-clocked asynchronous counter
// - standalone event on period match, or gate falling edge in gated mode
// - run bit 15 starts the timer when 1, stops it when 0
// - idle-halt bit 13 stops counting in idle when 1
// - gate bit 6 acts only with internal clock, ignored on external clock
// - prescale bits 5-4: 11 1:256, 10 1:64, 01 1:8, 00 1:1
// - standalone bit 2 picks synchronised or unsynchronised pin clock; ignored internally
// - source bit 1 selects pin rising edges (1) or core clock (0)
// - pair runs as two 16-bit timers, one 32-bit timer or counter
// - join bit 3 of lower control merges the pair into 32 bits
// - joined: lower holds low count and period words, upper the high words
// - joined: upper control ignored; lower control, clock and gate used
// - joined: full 32-bit match raises the upper timer's event
// - run bit starts whole 32-bit timer when joined, else lower only
// - first pair triggers first converter, second pair the second converter
// - only first pair timers request DMA and serve as capture bases
// - timers keep running in idle when allowed, and on pin clocks; here idle-halt bit 13 stops pin-clocked timers in idle too
// - unimplemented control bits read zero and ignore writes
module timer_set
  import timer_set_pkg::*;
#(
  parameter int NUM_PAIRS_P = NUM_PAIRS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idle_mode,
  input wire logic [2*NUM_PAIRS_P:0] ext_clock_pin,
  output logic [2*NUM_PAIRS_P:0] timer_event,
  output logic [1:0] adc_trigger,
  output logic [1:0] dma_request,
  output logic [15:0] capture_base_lower,
  output logic [15:0] capture_base_upper
);

  localparam int NT = 1 + 2 * NUM_PAIRS_P;
  localparam logic [3:0] NT4 = 4'(NT);

  if (NUM_PAIRS_P < MIN_PAIRS || NUM_PAIRS_P > MAX_PAIRS) begin : g_pairs_check
    $error("timer_set: NUM_PAIRS_P out of range");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [NT-1:0][15:0] ctrl;
    logic [NT-1:0][15:0] period;
    logic [NT-1:0][15:0] count;
    logic [NT-1:0][7:0] pre;
    logic [NT-1:0] s1;
    logic [NT-1:0] s2;
    logic [NT-1:0] s3;
    logic [NT-1:0] s4;
    logic [NT-1:0] evt;
    logic [NT-1:0] flags;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s;
  state_t next_s;
  logic [NT-1:0] tick;
  logic [NT-1:0] gate_fall;
  logic [NT-1:0] run;
  logic wr_do;

  // ==========================================================
  // helpers
  function automatic logic [7:0] term_of(input logic [1:0] ps);
    logic [7:0] t;
    unique case (ps)
      PS_DIV1: t = TERM_DIV1;
      PS_DIV8: t = TERM_DIV8;
      PS_DIV64: t = TERM_DIV64;
      PS_DIV256: t = TERM_DIV256;
    endcase
    return t;
  endfunction

  function automatic logic [15:0] mask_of(input int i);
    if (i == 0) begin
      return STANDALONE_MASK;
    end
    return (i % 2 == 1) ? LOWER_MASK : UPPER_MASK;
  endfunction

  function automatic logic slot_hit(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:SLOT_SHIFT] < NT4 && a[3:2] != 2'h3;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic src;
    logic edge_src;
    logic gated;
    logic [31:0] c32;
    logic [31:0] p32;
    logic [3:0] idx;
    logic [15:0] wd;
    int lo;
    int up;
    src = 1'b0;
    edge_src = 1'b0;
    gated = 1'b0;
    c32 = 32'h0000_0000;
    p32 = 32'h0000_0000;
    idx = 4'h0;
    wd = 16'h0000;
    lo = 0;
    up = 0;
    next_s = s;
    next_s.evt = '0;
    tick = '0;
    gate_fall = '0;
    run = '0;
    // pins: two-stage synchroniser, then edge and extra sync stage
    next_s.s1 = ext_clock_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.s4 = s.s3;

    for (int i = 0; i < NT; i++) begin
      // unsynchronised mode skips the alignment stage, saving a cycle of latency
      if (i == 0 && !s.ctrl[0][SYNC_BIT]) begin
        edge_src = s.s2[i] & ~s.s3[i];
      end else begin
        edge_src = s.s3[i] & ~s.s4[i];
      end
      gated = !s.ctrl[i][SOURCE_BIT] && s.ctrl[i][GATE_BIT];
      if (s.ctrl[i][SOURCE_BIT]) begin
        src = edge_src;
      end else begin
        src = gated ? s.s2[i] : 1'b1;
      end
      gate_fall[i] = gated && s.s3[i] && !s.s2[i];
      run[i] = s.ctrl[i][RUN_BIT] && !(idle_mode && s.ctrl[i][IDLE_HALT_BIT]);
      tick[i] = run[i] && src && s.pre[i] == term_of(s.ctrl[i][PRESCALE_LO +: 2]);
      if (!run[i]) begin
        next_s.pre[i] = 8'h00;
      end else if (src) begin
        next_s.pre[i] = tick[i] ? 8'h00 : s.pre[i] + 8'h01;
      end
      if (tick[i]) begin
        if (s.count[i] == s.period[i]) begin
          next_s.count[i] = 16'h0000;
          next_s.evt[i] = 1'b1;
        end else begin
          next_s.count[i] = s.count[i] + 16'h0001;
        end
      end
      if (gate_fall[i]) begin
        next_s.evt[i] = 1'b1;
      end
    end

    // joined pairs: lower timer's controls drive one 32-bit counter
    for (int p = 0; p < NUM_PAIRS_P; p++) begin
      lo = 1 + 2 * p;
      up = lo + 1;
      if (s.ctrl[lo][JOIN_BIT]) begin
        c32 = {s.count[up], s.count[lo]};
        p32 = {s.period[up], s.period[lo]};
        next_s.pre[up] = 8'h00;
        next_s.count[up] = s.count[up];
        next_s.evt[lo] = 1'b0;
        next_s.evt[up] = gate_fall[lo];
        if (tick[lo]) begin
          if (c32 == p32) begin
            c32 = 32'h0000_0000;
            next_s.evt[up] = 1'b1;
          end else begin
            c32 = c32 + 32'h0000_0001;
          end
          next_s.count[lo] = c32[15:0];
          next_s.count[up] = c32[31:16];
        end
      end
    end

    // ==========================================================
    // bus slave: write path
    if (s_axi_awvalid && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    wr_do = s.aw_full && s.w_full && !s.bvalid;
    idx = s.aw_addr[ADDR_W-1:SLOT_SHIFT];
    if (wr_do) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.aw_addr == FLAGS_OFFSET) begin
        wd = merge(16'h0000, s.w_data, s.w_strb);
        next_s.flags = s.flags & ~wd[NT-1:0];
      end else if (slot_hit(s.aw_addr)) begin
        unique case (s.aw_addr[3:2])
          SEL_CTRL: begin
            wd = merge(s.ctrl[idx], s.w_data, s.w_strb);
            next_s.ctrl[idx] = wd & mask_of(int'(idx));
          end
          SEL_PERIOD: begin
            next_s.period[idx] = merge(s.period[idx], s.w_data, s.w_strb);
          end
          SEL_COUNT: begin
            next_s.count[idx] = merge(s.count[idx], s.w_data, s.w_strb);
          end
          default: begin
            next_s.bresp = RESP_SLVERR;
          end
        endcase
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    // a new event beats a clear in the same cycle
    next_s.flags = next_s.flags | next_s.evt;

    // ==========================================================
    // bus slave: read path
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      idx = s_axi_araddr[ADDR_W-1:SLOT_SHIFT];
      if (s_axi_araddr == FLAGS_OFFSET) begin
        next_s.rdata[NT-1:0] = s.flags;
      end else if (slot_hit(s_axi_araddr)) begin
        unique case (s_axi_araddr[3:2])
          SEL_CTRL: next_s.rdata[15:0] = s.ctrl[idx];
          SEL_PERIOD: next_s.rdata[15:0] = s.period[idx];
          SEL_COUNT: next_s.rdata[15:0] = s.count[idx];
          default: next_s.rresp = RESP_SLVERR;
        endcase
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      for (int i = 0; i < NT; i++) begin
        s.ctrl[i] <= CTRL_RESET;
        s.period[i] <= PERIOD_RESET;
        s.count[i] <= COUNT_RESET;
      end
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !s.aw_full;
  assign s_axi_wready = !s.w_full;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timer_event = s.evt;
  assign adc_trigger = {s.evt[4], s.evt[2]};
  assign dma_request = {s.evt[2], s.evt[1]};
  assign capture_base_lower = s.count[1];
  assign capture_base_upper = s.count[2];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_both_held;
    s.aw_full && s.w_full && !s.bvalid;
  endsequence

  sequence s_resp_out;
    s_axi_bvalid && s_axi_awready && s_axi_wready;
  endsequence

  a_stop_holds: assert property (!s.ctrl[0][RUN_BIT] && !wr_do |=> $stable(s.count[0]))
    else $error("stopped standalone count moved");

  a_match_wraps: assert property (tick[0] && s.count[0] == s.period[0] && !wr_do
    |=> s.count[0] == 16'h0000 && s.evt[0])
    else $error("period match did not wrap and signal");

  a_idle_halts: assert property (idle_mode && s.ctrl[0][IDLE_HALT_BIT] |-> !tick[0])
    else $error("timer ticked in idle with halt set");

  a_gate_external: assert property (s.ctrl[0][SOURCE_BIT] |-> !gate_fall[0])
    else $error("gate acted with external clock");

  a_div8_spacing: assert property (tick[0] && s.ctrl[0][PRESCALE_LO +: 2] == PS_DIV8
    && !s.ctrl[0][SOURCE_BIT] && !s.ctrl[0][GATE_BIT] |=> !tick[0] [*7])
    else $error("1:8 prescale ticked too soon");

  a_join_event: assert property (s.ctrl[1][JOIN_BIT] && tick[1]
    && {s.count[2], s.count[1]} == {s.period[2], s.period[1]} && !wr_do
    |=> s.evt[2] && !s.evt[1] && s.count[1] == 16'h0000 && s.count[2] == 16'h0000)
    else $error("32-bit match not signalled on upper timer");

  a_upper_ignored: assert property (s.ctrl[1][JOIN_BIT] |-> s.pre[2] == 8'h00
    || $past(!s.ctrl[1][JOIN_BIT]))
    else $error("upper prescaler ran while joined");

  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  a_write_answer: assert property (s_both_held |=> s_resp_out)
    else $error("write response missing");

  a_event_sticks: assert property (s.evt[0] |-> s.flags[0])
    else $error("event flag lost");

  a_joined_stopped: assert property (s.ctrl[1][JOIN_BIT] && !s.ctrl[1][RUN_BIT]
    && !wr_do |=> $stable(s.count[1]) && $stable(s.count[2]))
    else $error("stopped joined pair count moved");

  a_upper_alone: assert property (!s.ctrl[1][JOIN_BIT] && !s.ctrl[2][RUN_BIT]
    && !wr_do |=> $stable(s.count[2]))
    else $error("unjoined upper count moved without its run bit");

endmodule

// >>> timer_set_pkg.sv
package timer_set_pkg;

  // ==========================================================
  // clock and sizing
  localparam int CLK_PERIOD_NS = 5;
  localparam int NUM_PAIRS = 4;
  localparam int MIN_PAIRS = 2;
  localparam int MAX_PAIRS = 7;
  localparam int ADDR_W = 8;

  // ==========================================================
  // register map: one 16-byte slot per timer, flags at the top
  localparam int SLOT_SHIFT = 4;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_PERIOD = 2'h1;
  localparam logic [1:0] SEL_COUNT = 2'h2;
  localparam logic [7:0] FLAGS_OFFSET = 8'hF0;

  // ==========================================================
  // control field positions
  localparam int RUN_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PRESCALE_LO = 4;
  localparam int JOIN_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int SOURCE_BIT = 1;

  // implemented bits per control register kind
  localparam logic [15:0] STANDALONE_MASK = 16'hA076;
  localparam logic [15:0] LOWER_MASK = 16'hA07A;
  localparam logic [15:0] UPPER_MASK = 16'hA072;

  // ==========================================================
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==========================================================
  // prescale codes and their terminal counts
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] TERM_DIV1 = 8'h00;
  localparam logic [7:0] TERM_DIV8 = 8'h07;
  localparam logic [7:0] TERM_DIV64 = 8'h3F;
  localparam logic [7:0] TERM_DIV256 = 8'hFF;

  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> timer_set_tb.sv
`timescale 1ns/1ps
module timer_set_tb
  import timer_set_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic idle_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, adc_trigger, dma_request;
  logic [31:0] rdata;
  logic [15:0] cap_lo, cap_hi;
  logic [1:0] last_bresp = 2'h0;
  logic [2*NUM_PAIRS:0] ext_clock_pin, timer_event;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int dv[4] = '{1, 8, 64, 256};

  always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

  timer_set dut (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .idle_mode(idle_mode), .ext_clock_pin(ext_clock_pin), .timer_event(timer_event),
    .adc_trigger(adc_trigger), .dma_request(dma_request),
    .capture_base_lower(cap_lo), .capture_base_upper(cap_hi)
  );

  ext_pin_model #(.W(2*NUM_PAIRS+1)) pm (.clk(clk), .pin(ext_clock_pin));

  // ==========================================================
  // bus and compare helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(negedge clk); while (bvalid !== 1'b1);
    last_bresp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("read data", exp, d);
  endtask

  function automatic logic pick(input int s);
    if (s == 9) return adc_trigger[0];
    if (s == 10) return dma_request[1];
    if (s == 11) return adc_trigger[1];
    if (s == 12) return dma_request[0];
    return timer_event[s];
  endfunction

  task automatic ev_cnt(input int s, input int cyc, input int exp);
    int c;
    c = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (pick(s) === 1'b1) c++;
    end
    chk("event count", exp, c);
  endtask

  // first two gaps may straddle the old setting, so only the third is judged
  task automatic ev_gap(input int s, input int g);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (pick(s) !== 1'b1 && n < 2000);
    end
    chk("event gap", g, n);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_FFFF);
    rd_chk(8'h10, 32'h0000_0000);
    wr(8'h00, 16'hFFFF);
    rd_chk(8'h00, {16'h0000, STANDALONE_MASK});
    wr(8'h10, 16'hFFFF);
    rd_chk(8'h10, {16'h0000, LOWER_MASK});
    wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, {16'h0000, UPPER_MASK});
    wr(8'h00, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h20, 16'h0000);
    chk("mapped write resp", {30'h0, RESP_OKAY}, {30'h0, last_bresp});
    wr(8'hC0, 16'h1234);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
    rd(8'hC0, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask

  task automatic t_prescale;
    wr(8'h04, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 16'(32'h8000 | (k << PRESCALE_LO)));
      ev_gap(0, 2 * dv[k]);
    end
  endtask

  task automatic t_stop_idle;
    wr(8'h00, 16'h0000);
    ev_cnt(0, 40, 0);
    wr(8'h00, 16'hA000);
    @(posedge clk);
    idle_mode <= 1'b1;
    // an event from the last tick before idle still shows for one cycle
    @(posedge clk);
    ev_cnt(0, 40, 0);
    wr(8'h00, 16'h8000);
    ev_gap(0, 2);
    @(posedge clk);
    idle_mode <= 1'b0;
  endtask

  // gate bit set on purpose: with the pin clock it must change nothing
  task automatic t_ext;
    logic [15:0] v[2] = '{16'h8046, 16'h8042};
    wr(8'h04, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, v[k]);
      wr(8'h08, 16'h0000);
      fork
        pm.pulses(0, 6);
        ev_cnt(0, 70, 2);
      join
    end
  endtask

  task automatic t_gate;
    wr(8'h04, 16'hFFFF);
    wr(8'h00, 16'h8040);
    wr(8'h08, 16'h0000);
    fork
      pm.gate(0, 10);
      ev_cnt(0, 30, 1);
    join
    rd_chk(8'h08, 32'h0000_000A);
    wr(8'h00, 16'h0000);
    rd_chk(8'hF0, 32'h0000_0001);
    wr(8'hF0, 16'h0001);
    rd_chk(8'hF0, 32'h0000_0000);
  endtask

  task automatic t_pair;
    wr(8'h14, 16'h0001);
    wr(8'h24, 16'h0000);
    wr(8'h18, 16'h0000);
    wr(8'h28, 16'h0000);
    wr(8'h20, 16'h0030);
    wr(8'h10, 16'h0008);
    wr(8'h10, 16'h8008);
    ev_gap(2, 2);
    ev_cnt(1, 20, 0);
    ev_cnt(9, 20, 10);
    ev_cnt(10, 20, 10);
    wr(8'h20, 16'h0000);
    wr(8'h10, 16'h8000);
    ev_gap(1, 2);
    ev_cnt(12, 20, 10);
    ev_cnt(2, 20, 0);
    wr(8'h44, 16'h0001);
    wr(8'h40, 16'h8000);
    ev_cnt(11, 20, 10);
    wr(8'h40, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h18, 16'h1234);
    wr(8'h28, 16'h5678);
    chk("capture lower", 32'h0000_1234, {16'h0000, cap_lo});
    chk("capture upper", 32'h0000_5678, {16'h0000, cap_hi});
  endtask

  // ==========================================================
  // run control
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("[ERR] run length expected 0 seen %0d", cycles);
      tally_and_finish;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_prescale;
    t_stop_idle;
    t_ext;
    t_gate;
    t_pair;
    tally_and_finish;
  end
endmodule
